// ===== tb/ssv_supply_model.sv
`timescale 1ns/1ps

module ssv_supply_model (
    // clock
    input wire logic mclk_in,
    // device side
    input wire logic [4:0] oe_in,
    input wire logic foe_in,
    // bench control
    input wire logic [4:0] drop_in,
    input wire logic pull_in,
    // rails
    output logic [4:0] uv_out,
    output logic [4:0] dl_out,
    output logic fw_out
);
    logic [4:0] last = 5'h1f;
    logic [2:0] age [5] = '{default: 3'h0};
    // rails settle 8 cycles after their switch moves, so a sequencer that skips its waits gets caught
    always_ff @(posedge mclk_in) begin
        last <= oe_in;
        for (int i = 0; i < 5; i++) begin
            age[i] <= (oe_in[i] !== last[i]) ? 3'h0 : age[i] + {2'h0, age[i] != 3'h7};
            // a switch that moved this cycle still carries its stale age, so it must not read as settled
            uv_out[i] <= !oe_in[i] && oe_in[i] === last[i] && age[i] == 3'h7 && !drop_in[i];
            dl_out[i] <= oe_in[i] && oe_in[i] === last[i] && age[i] == 3'h7;
        end
    end
    assign fw_out = !(foe_in || pull_in);
endmodule : ssv_supply_model

// ===== tb/test_supply_sequencer_supervisor.sv
`timescale 1ns/1ps
`define CK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end

module test_supply_sequencer_supervisor;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic en_ok = 1'b0, shutdown_n = 1'b1, hold = 1'b1, pull = 1'b0, rd = 1'b0, wr = 1'b0;
    logic internal_supply_node = 1'b0, topen = 1'b1, dopen = 1'b1;
    logic [4:0] ov = 5'h00, drop = 5'h00, ch_oe, dsc, uv, dl;
    logic [5:0] st = 6'h00;
    logic [3:0] addr = 4'h0;
    logic [31:0] wd = 32'h0, q, rdata;
    logic wq, rst_oe, ov_oe, flt_oe, irq, fw;
    int fail_count = 0, comparisons = 0;
    always #20 mclk_in = ~mclk_in;

    // short stand-ins for the fixed and capacitor intervals keep the run brief
    ssv_top #(.RST_FIXED_CYCLES(22'd100), .RST_CAP_CYCLES(22'd50), .DLY_CAP_CYCLES(22'd20))
        ssv_top_inst (.mclk_in(mclk_in), .reset_in(reset_in), .set_uv_ok_in(uv), .set_ov_in(ov),
        .enable_ok_in(en_ok), .disc_low_in(dl), .shutdown_n_in(shutdown_n), .enable_hold_in(hold),
        .fault_n_in(fw), .order_select_a_high_in(st[5]), .order_select_a_low_in(st[4]),
        .order_select_b_high_in(st[3]), .order_select_b_low_in(st[2]), .order_select_c_high_in(st[1]),
        .order_select_c_low_in(st[0]), .tmo_abp_in(internal_supply_node), .tmo_open_in(topen), .dly_open_in(dopen),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(4'hf), .avs_readdata_out(rdata), .avs_waitrequest_out(wq),
        .channel_out_oe_out(ch_oe), .discharge_en_out(dsc), .reset_n_oe_out(rst_oe),
        .overvoltage_flag_n_oe_out(ov_oe), .fault_n_o_out(), .fault_n_oe_out(flt_oe), .irq_out(irq));
    ssv_supply_model ssv_supply_model_inst (.mclk_in(mclk_in), .oe_in(ch_oe), .foe_in(flt_oe),
        .drop_in(drop), .pull_in(pull), .uv_out(uv), .dl_out(dl), .fw_out(fw));

    task print_verdict;
        $display("counts: %0d compared, %0d bad", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict

    task stall;
        fail_count++;
        $display("BAD wait exp done got timeout");
        print_verdict;
    endtask : stall

    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_in);
        addr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        do begin
            @(posedge mclk_in);
            n++;
        end while (wq !== 1'b0 && n < 50);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        if (wq !== 1'b0) stall;
    endtask : bus

    // follows four channel moves, slot order packed two bits each with the first slot lowest
    task seq(input logic up, input logic [7:0] ord, input int gmin, input int tmin);
        logic [4:0] prev;
        int k, n, last;
        k = 0;
        n = 0;
        last = 0;
        prev = ch_oe;
        while (k < 4 && n < 5000) begin
            @(posedge mclk_in);
            n++;
            for (int i = 0; i < 4; i++) begin
                if ((up ? prev[i] & ~ch_oe[i] : ~prev[i] & ch_oe[i]) === 1'b1) begin
                    `CK("slot", ord[2*k+:2], 2'(i))
                    if (up && k > 0) `CK("gap", 1'b1, (n - last) >= gmin)
                    k++;
                    last = n;
                end
            end
            prev = ch_oe;
        end
        if (k < 4) stall;
        if (up) begin
            `CK("rst held", 1'b1, rst_oe)
            while (rst_oe !== 1'b0 && n - last < 2000) begin
                @(posedge mclk_in);
                n++;
            end
            `CK("timeout", 1'b1, (n - last) inside {[tmin:tmin + 50]})
            `CK("dsc off", 4'h0, dsc[3:0])
        end
    endtask : seq

    initial begin
        repeat (8) @(posedge mclk_in);
        reset_in <= 1'b0;
        bus(1'b1, 4'h4, 32'h8);
        bus(1'b0, 4'h4, 32'h0);
        `CK("mask", 32'h8, q)
        `CK("idle", 5'h1f, ch_oe)
        en_ok <= 1'b1;
        seq(1'b1, 8'he4, 250, 250);
        repeat (3) @(posedge mclk_in);
        `CK("irq", 1'b1, irq)
        bus(1'b0, 4'h0, 32'h0);
        `CK("status", 1'b1, q[3])
        bus(1'b1, 4'h0, 32'h8);
        repeat (3) @(posedge mclk_in);
        `CK("irq clr", 1'b0, irq)
        $display("test power-up done");
        ov <= 5'h02;
        repeat (5) @(posedge mclk_in);
        `CK("ov on", 1'b1, ov_oe)
        ov <= 5'h00;
        repeat (5) @(posedge mclk_in);
        `CK("ov off", 1'b0, ov_oe)
        $display("test overvoltage done");
        hold <= 1'b0;
        shutdown_n <= 1'b0;
        repeat (20) @(posedge mclk_in);
        `CK("held on", 4'h0, ch_oe[3:0])
        `CK("rst sd", 1'b1, rst_oe)
        hold <= 1'b1;
        seq(1'b0, 8'h1b, 0, 0);
        `CK("dsc on", 4'hf, dsc[3:0])
        $display("test shutdown done");
        shutdown_n <= 1'b1;
        st <= 6'h18;
        seq(1'b1, 8'h36, 250, 250);
        $display("test order done");
        drop <= 5'h04;
        repeat (6) @(posedge mclk_in);
        `CK("flt out", 1'b1, flt_oe)
        `CK("all off", 4'hf, ch_oe[3:0])
        drop <= 5'h00;
        topen <= 1'b0;
        seq(1'b1, 8'h36, 250, 50);
        pull <= 1'b1;
        repeat (6) @(posedge mclk_in);
        `CK("ext off", 4'hf, ch_oe[3:0])
        bus(1'b0, 4'h0, 32'h0);
        `CK("ext ev", 1'b1, q[2])
        pull <= 1'b0;
        $display("test fault done");
        st <= 6'h26;
        dopen <= 1'b0;
        internal_supply_node <= 1'b1;
        seq(1'b1, 8'h1b, 20, 100);
        bus(1'b1, 4'h8, 32'h1);
        seq(1'b0, 8'he4, 0, 0);
        repeat (20) @(posedge mclk_in);
        bus(1'b0, 4'hc, 32'h0);
        `CK("state", 32'h3f, q)
        $display("test straps done");
        print_verdict;
    end
endmodule : test_supply_sequencer_supervisor

// ===== verilog/ssv_params.svh
`ifndef SSV_PARAMS_SVH
`define SSV_PARAMS_SVH

// clock and derived cycle counts (least times round up)
`define SSV_CLK_NS 40
`define SSV_CYC_UP(ns) (((ns) + `SSV_CLK_NS - 1) / `SSV_CLK_NS)
`define SSV_DLY_OPEN_NS 10000
`define SSV_DLY_OPEN_CYC `SSV_CYC_UP(`SSV_DLY_OPEN_NS)
`define SSV_RST_OPEN_NS 10000
`define SSV_RST_OPEN_CYC `SSV_CYC_UP(`SSV_RST_OPEN_NS)
`define SSV_RST_FIXED_NS 128000000
`define SSV_RST_FIXED_CYC `SSV_CYC_UP(`SSV_RST_FIXED_NS)
`define SSV_FLT_PULSE_NS 1900
`define SSV_FLT_PULSE_CYC `SSV_CYC_UP(`SSV_FLT_PULSE_NS)
// capacitor-set intervals stand in as plain defaults
`define SSV_RST_CAP_CYC 25000
`define SSV_DLY_CAP_CYC 2500

`define SSV_TMR_W 22
`define SSV_SYNC_W 28
`define SSV_NCH 5

// register byte offsets
`define SSV_REG_STATUS 4'h0
`define SSV_REG_MASK 4'h4
`define SSV_REG_CTRL 4'h8
`define SSV_REG_STATE 4'hc

// event bit positions in status and mask
`define SSV_EV_UV 0
`define SSV_EV_OV 1
`define SSV_EV_EXT 2
`define SSV_EV_UP 3
`define SSV_EV_DOWN 4
`define SSV_EV_W 5

// power-up order 1-2-3-4(-5), three bits per slot, first slot lowest
`define SSV_ORDER_NAT 15'h4688

`endif

// ===== verilog/ssv_pkg.sv
`include "ssv_params.svh"

package ssv_pkg;
    typedef enum logic [2:0] {
        ST_OFF = 3'h0,
        ST_DELAY = 3'h1,
        ST_CHECK = 3'h3,
        ST_RUN = 3'h2,
        ST_REV = 3'h6,
        ST_FAULT = 3'h4
    } ssv_state_t;

    typedef struct packed {
        ssv_state_t st;
        logic [2:0] idx;
        logic [`SSV_NCH-1:0] pull;
        logic [`SSV_NCH-1:0] chk;
        logic [14:0] ord;
        logic rst_oe;
        logic ov_oe;
        logic flt_oe;
        logic [`SSV_NCH-1:0] dsc;
        logic [`SSV_EV_W-1:0] sts;
        logic [`SSV_EV_W-1:0] msk;
        logic sd;
        logic irq;
        logic wreq;
        logic [31:0] rdata;
    } ssv_core_t;

    typedef struct packed {
        logic [`SSV_TMR_W-1:0] count;
    } ssv_tmr_t;

    typedef struct packed {
        logic [`SSV_SYNC_W-1:0] s2;
        logic [`SSV_SYNC_W-1:0] s1;
    } ssv_sync_t;
endpackage : ssv_pkg

// ===== verilog/ssv_sync.sv
`timescale 1ns/1ps
`include "ssv_params.svh"

module ssv_sync (
    // clock and reset
    input wire logic mclk_in,
    input wire logic reset_in,
    // levels
    input wire logic [`SSV_SYNC_W-1:0] raw_in,
    output logic [`SSV_SYNC_W-1:0] sync_out
);
    ssv_pkg::ssv_sync_t sync_reg;
    ssv_pkg::ssv_sync_t sync_next;

    // first stage feeds only the second stage
    always_comb begin
        sync_next = sync_reg;
        sync_next.s1 = raw_in;
        sync_next.s2 = sync_reg.s1;
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg.s2;
endmodule : ssv_sync

// ===== verilog/ssv_timer.sv
`timescale 1ns/1ps
`include "ssv_params.svh"

module ssv_timer (
    // clock and reset
    input wire logic mclk_in,
    input wire logic reset_in,
    // control
    input wire logic run_in,
    input wire logic [`SSV_TMR_W-1:0] limit_in,
    output logic done_out
);
    ssv_pkg::ssv_tmr_t tmr_reg;
    ssv_pkg::ssv_tmr_t tmr_next;

    // counts while run is high, restarts from zero when it drops, parks at the limit
    always_comb begin
        tmr_next = tmr_reg;
        if (!run_in) begin
            tmr_next.count = '0;
        end else if (!done_out) begin
            tmr_next.count = tmr_reg.count + `SSV_TMR_W'(1);
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            tmr_reg <= '0;
        end else begin
            tmr_reg <= tmr_next;
        end
    end

    assign done_out = (tmr_reg.count >= limit_in);
endmodule : ssv_timer

// ===== verilog/ssv_top.sv
`timescale 1ns/1ps
`include "ssv_params.svh"

module ssv_top #(
    parameter bit FIVE_CH = 1'b0,
    parameter logic [`SSV_TMR_W-1:0] RST_FIXED_CYCLES = `SSV_TMR_W'(`SSV_RST_FIXED_CYC),
    parameter logic [`SSV_TMR_W-1:0] RST_CAP_CYCLES = `SSV_TMR_W'(`SSV_RST_CAP_CYC),
    parameter logic [`SSV_TMR_W-1:0] DLY_CAP_CYCLES = `SSV_TMR_W'(`SSV_DLY_CAP_CYC)
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic reset_in,
    // digitised comparators
    input wire logic [`SSV_NCH-1:0] set_uv_ok_in,
    input wire logic [`SSV_NCH-1:0] set_ov_in,
    input wire logic enable_ok_in,
    input wire logic [`SSV_NCH-1:0] disc_low_in,
    // control inputs
    input wire logic shutdown_n_in,
    input wire logic enable_hold_in,
    input wire logic fault_n_in,
    // straps
    input wire logic order_select_a_high_in,
    input wire logic order_select_a_low_in,
    input wire logic order_select_b_high_in,
    input wire logic order_select_b_low_in,
    input wire logic order_select_c_high_in,
    input wire logic order_select_c_low_in,
    input wire logic tmo_abp_in,
    input wire logic tmo_open_in,
    input wire logic dly_open_in,
    // avalon-mm slave
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // open-drain pins, high enable pulls low
    output logic [`SSV_NCH-1:0] channel_out_oe_out,
    output logic [`SSV_NCH-1:0] discharge_en_out,
    output logic reset_n_oe_out,
    output logic overvoltage_flag_n_oe_out,
    output logic fault_n_o_out,
    output logic fault_n_oe_out,
    // interrupt
    output logic irq_out
);
    localparam logic [2:0] NCH = FIVE_CH ? 3'h5 : 3'h4;
    localparam logic [`SSV_NCH-1:0] USED = FIVE_CH ? 5'h1f : 5'h0f;

    ssv_pkg::ssv_core_t core_reg;
    ssv_pkg::ssv_core_t core_next;
    logic [`SSV_SYNC_W-1:0] raw_s;
    logic [`SSV_SYNC_W-1:0] sync_s;
    logic [`SSV_NCH-1:0] uv_s;
    logic [`SSV_NCH-1:0] ov_s;
    logic [`SSV_NCH-1:0] disc_s;
    logic en_s;
    logic shutdown_n_s;
    logic hold_s;
    logic fault_s;
    logic [4:0] tri_row;
    logic [2:0] cur;
    logic [2:0] rev_ch;
    logic shutdown_n_eff;
    logic uv_bad;
    logic rst_cause;
    logic seq_done;
    logic rst_done;
    logic flt_done;
    logic [`SSV_TMR_W-1:0] seq_limit;
    logic [`SSV_TMR_W-1:0] rst_limit;
    logic acc;
    logic [`SSV_EV_W-1:0] ev;
    logic [`SSV_EV_W-1:0] w1c;

    function automatic logic [1:0] trit(input logic hi, input logic lo);
        // floating reads 0, low 1, high 2
        if (hi && !lo) begin
            return 2'h2;
        end else if (lo && !hi) begin
            return 2'h1;
        end
        return 2'h0;
    endfunction : trit

    // slot codes {4th,3rd,2nd,1st}, two bits each; fifth slot is always channel five
    function automatic logic [14:0] order_row(input logic [4:0] row);
        logic [7:0] e;
        e = 8'he4;
        case (row)
            5'd1: e = 8'hb4;
            5'd2: e = 8'hd8;
            5'd3: e = 8'h78;
            5'd4: e = 8'h9c;
            5'd5: e = 8'h6c;
            5'd6: e = 8'he1;
            5'd7: e = 8'hb1;
            5'd8: e = 8'hc9;
            5'd9: e = 8'h39;
            5'd10: e = 8'h8d;
            5'd11: e = 8'h2d;
            5'd12: e = 8'hd2;
            5'd13: e = 8'h72;
            5'd14: e = 8'hc6;
            5'd15: e = 8'h36;
            5'd16: e = 8'h4e;
            5'd17: e = 8'h1e;
            5'd18: e = 8'h93;
            5'd19: e = 8'h63;
            5'd20: e = 8'h87;
            5'd21: e = 8'h27;
            5'd22: e = 8'h4b;
            5'd23: e = 8'h1b;
            default: e = 8'he4;
        endcase
        return {3'h4, 1'b0, e[7:6], 1'b0, e[5:4], 1'b0, e[3:2], 1'b0, e[1:0]};
    endfunction : order_row

    assign raw_s = {dly_open_in, tmo_open_in, tmo_abp_in,
                    order_select_c_low_in, order_select_c_high_in,
                    order_select_b_low_in, order_select_b_high_in,
                    order_select_a_low_in, order_select_a_high_in,
                    disc_low_in, fault_n_in, enable_hold_in, shutdown_n_in, enable_ok_in, set_ov_in, set_uv_ok_in};

    ssv_sync u_sync (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .raw_in(raw_s),
        .sync_out(sync_s)
    );

    assign uv_s = sync_s[4:0];
    assign ov_s = sync_s[9:5];
    assign en_s = sync_s[10];
    assign shutdown_n_s = sync_s[11];
    assign hold_s = sync_s[12];
    assign fault_s = sync_s[13];
    assign disc_s = sync_s[18:14];
    // ternary code, first input most significant; the three unlisted codes fall back to natural order
    assign tri_row = 5'(9 * trit(sync_s[19], sync_s[20]) + 3 * trit(sync_s[21], sync_s[22])
                     + trit(sync_s[23], sync_s[24]));

    assign seq_limit = sync_s[27] ? `SSV_TMR_W'(`SSV_DLY_OPEN_CYC) : DLY_CAP_CYCLES;
    assign rst_limit = sync_s[25] ? RST_FIXED_CYCLES :
                       (sync_s[26] ? `SSV_TMR_W'(`SSV_RST_OPEN_CYC) : RST_CAP_CYCLES);

    assign cur = core_reg.ord[3 * core_reg.idx +: 3];
    assign rev_ch = core_reg.ord[3 * (core_reg.idx - 3'h1) +: 3];
    assign shutdown_n_eff = shutdown_n_s && !core_reg.sd;
    // only channels whose monitor has once passed can fault
    assign uv_bad = |(core_reg.chk & ~uv_s & USED);
    assign rst_cause = !(&(uv_s | ~USED)) || !en_s || !shutdown_n_eff || !fault_s
                       || (core_reg.st != ssv_pkg::ST_RUN);
    assign acc = (avs_read_in || avs_write_in) && !core_reg.wreq;

    ssv_timer u_seq_tmr (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .run_in(core_reg.st == ssv_pkg::ST_DELAY),
        .limit_in(seq_limit),
        .done_out(seq_done)
    );

    ssv_timer u_rst_tmr (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .run_in(!rst_cause),
        .limit_in(rst_limit),
        .done_out(rst_done)
    );

    ssv_timer u_flt_tmr (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .run_in(core_reg.st == ssv_pkg::ST_FAULT),
        .limit_in(`SSV_TMR_W'(`SSV_FLT_PULSE_CYC)),
        .done_out(flt_done)
    );

    always_comb begin
        core_next = core_reg;
        ev = '0;
        w1c = '0;
        case (core_reg.st)
            ssv_pkg::ST_OFF: begin
                core_next.pull = '1;
                core_next.chk = '0;
                core_next.idx = 3'h0;
                if (en_s && shutdown_n_eff && fault_s && (&(disc_s | ~USED))) begin
                    core_next.ord = FIVE_CH ? `SSV_ORDER_NAT : order_row(tri_row);
                    core_next.st = ssv_pkg::ST_DELAY;
                end
            end
            ssv_pkg::ST_DELAY: begin
                if (seq_done) begin
                    core_next.pull[cur] = 1'b0;
                    core_next.st = ssv_pkg::ST_CHECK;
                end
            end
            ssv_pkg::ST_CHECK: begin
                // the next release waits for this channel's monitor
                if (uv_s[cur]) begin
                    core_next.chk[cur] = 1'b1;
                    core_next.idx = core_reg.idx + 3'h1;
                    core_next.st = (core_reg.idx + 3'h1 == NCH) ? ssv_pkg::ST_RUN : ssv_pkg::ST_DELAY;
                end
            end
            ssv_pkg::ST_RUN: begin
                core_next.st = ssv_pkg::ST_RUN;
            end
            ssv_pkg::ST_REV: begin
                if (core_reg.idx == 3'h0) begin
                    core_next.st = ssv_pkg::ST_OFF;
                    ev[`SSV_EV_DOWN] = 1'b1;
                end else begin
                    core_next.pull[rev_ch] = 1'b1;
                    core_next.chk[rev_ch] = 1'b0;
                    // no delay between steps: the next goes once this supply has discharged
                    if (core_reg.pull[rev_ch] && disc_s[rev_ch]) begin
                        core_next.idx = core_reg.idx - 3'h1;
                    end
                end
            end
            ssv_pkg::ST_FAULT: begin
                core_next.pull = '1;
                core_next.chk = '0;
                if (flt_done) begin
                    core_next.st = ssv_pkg::ST_OFF;
                end
            end
            default: begin
                core_next.st = ssv_pkg::ST_OFF;
            end
        endcase
        // own drive of the fault line is masked so it is not mistaken for an outside pull
        if (core_reg.st != ssv_pkg::ST_OFF && core_reg.st != ssv_pkg::ST_FAULT) begin
            if (!fault_s && !core_reg.flt_oe) begin
                core_next.st = ssv_pkg::ST_OFF;
                core_next.pull = '1;
                core_next.chk = '0;
                ev[`SSV_EV_EXT] = 1'b1;
            end else if (!en_s) begin
                core_next.st = ssv_pkg::ST_OFF;
                core_next.pull = '1;
                core_next.chk = '0;
            end else if (core_reg.st != ssv_pkg::ST_REV) begin
                if (uv_bad && shutdown_n_eff) begin
                    core_next.st = ssv_pkg::ST_FAULT;
                    core_next.pull = '1;
                    core_next.chk = '0;
                    ev[`SSV_EV_UV] = 1'b1;
                end else if (!shutdown_n_eff && hold_s) begin
                    core_next.st = ssv_pkg::ST_REV;
                    core_next.idx = (core_reg.st == ssv_pkg::ST_CHECK) ? core_reg.idx + 3'h1 : core_reg.idx;
                end
            end
        end
        core_next.flt_oe = (core_next.st == ssv_pkg::ST_FAULT);
        core_next.ov_oe = |(ov_s & USED);
        core_next.rst_oe = rst_cause || !rst_done;
        core_next.dsc = core_next.pull & USED & {`SSV_NCH{core_next.st == ssv_pkg::ST_OFF
                        || core_next.st == ssv_pkg::ST_FAULT || core_next.st == ssv_pkg::ST_REV}};
        ev[`SSV_EV_OV] = core_next.ov_oe && !core_reg.ov_oe;
        ev[`SSV_EV_UP] = core_reg.rst_oe && !core_next.rst_oe;
        // bus: one wait cycle, then the access completes at the edge where waitrequest is low
        core_next.wreq = !((avs_read_in || avs_write_in) && core_reg.wreq);
        if (avs_write_in && acc && avs_byteenable_in[0]) begin
            if (avs_address_in == `SSV_REG_STATUS) begin
                w1c = avs_writedata_in[`SSV_EV_W-1:0];
            end else if (avs_address_in == `SSV_REG_MASK) begin
                core_next.msk = avs_writedata_in[`SSV_EV_W-1:0];
            end else if (avs_address_in == `SSV_REG_CTRL) begin
                core_next.sd = avs_writedata_in[0];
            end
        end
        // a new event wins over a clear in the same cycle
        core_next.sts = (core_reg.sts & ~w1c) | ev;
        core_next.irq = |(core_next.sts & core_next.msk);
        if (avs_read_in && core_reg.wreq) begin
            if (avs_address_in == `SSV_REG_STATUS) begin
                core_next.rdata = {27'h0, core_reg.sts};
            end else if (avs_address_in == `SSV_REG_MASK) begin
                core_next.rdata = {27'h0, core_reg.msk};
            end else if (avs_address_in == `SSV_REG_CTRL) begin
                core_next.rdata = {31'h0, core_reg.sd};
            end else if (avs_address_in == `SSV_REG_STATE) begin
                core_next.rdata = {21'h0, core_reg.st, !fault_s, core_reg.ov_oe, core_reg.rst_oe, core_reg.pull};
            end else begin
                core_next.rdata = 32'h0;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            core_reg <= '0;
            core_reg.pull <= '1;
            core_reg.rst_oe <= 1'b1;
            core_reg.wreq <= 1'b1;
        end else begin
            core_reg <= core_next;
        end
    end

    assign channel_out_oe_out = core_reg.pull;
    assign discharge_en_out = core_reg.dsc;
    assign reset_n_oe_out = core_reg.rst_oe;
    assign overvoltage_flag_n_oe_out = core_reg.ov_oe;
    assign fault_n_o_out = 1'b0;
    assign fault_n_oe_out = core_reg.flt_oe;
    assign irq_out = core_reg.irq;
    assign avs_readdata_out = core_reg.rdata;
    assign avs_waitrequest_out = core_reg.wreq;

    default clocking dcb @(posedge mclk_in);
    endclocking
    default disable iff (reset_in);

    sequence rel_step_s;
        core_reg.st == ssv_pkg::ST_DELAY ##1 core_reg.st == ssv_pkg::ST_CHECK;
    endsequence
    sequence chk_pass_s;
        core_reg.st == ssv_pkg::ST_CHECK ##1 core_reg.st inside {ssv_pkg::ST_DELAY, ssv_pkg::ST_RUN};
    endsequence
    sequence rev_step_s;
        core_reg.st == ssv_pkg::ST_REV && core_reg.idx != 3'h0;
    endsequence

    sync_two_stage_a: assert property (!$past(reset_in, 2) && !$past(reset_in) |-> sync_s == $past(raw_s, 2))
        else $error("synchroniser is not two stages deep");
    check_pass_a: assert property (chk_pass_s |-> $past(uv_s[cur]))
        else $error("channel passed check with monitor low");
    ov_flag_a: assert property (overvoltage_flag_n_oe_out == $past(|(ov_s & USED)))
        else $error("overvoltage flag does not follow the monitors");
    reset_cause_a: assert property (rst_cause |=> reset_n_oe_out)
        else $error("reset released while a cause is present");
    reset_hold_a: assert property ($fell(reset_n_oe_out) |-> $past(rst_done) && $past(!rst_cause))
        else $error("reset released before the timeout ran out");
    fault_drive_a: assert property (core_reg.st == ssv_pkg::ST_RUN && uv_bad && en_s && shutdown_n_eff && fault_s
        |=> fault_n_oe_out && channel_out_oe_out == 5'h1f)
        else $error("fault line not pulled on undervoltage");
    ext_fault_a: assert property (core_reg.st == ssv_pkg::ST_RUN && !fault_s && !fault_n_oe_out
        |=> channel_out_oe_out == 5'h1f && core_reg.st == ssv_pkg::ST_OFF)
        else $error("outside fault did not drop all channels");
    rev_order_a: assert property (rev_step_s |=> channel_out_oe_out[$past(rev_ch)])
        else $error("reverse step did not pull the expected channel");
    seq_delay_a: assert property (rel_step_s |-> $past(seq_done))
        else $error("channel released before the sequence delay");
    order_nat_a: assert property (!FIVE_CH && core_reg.st == ssv_pkg::ST_OFF && core_next.st == ssv_pkg::ST_DELAY
        && tri_row == 5'h0 ##1 1'b1 |-> core_reg.ord == 15'h4688)
        else $error("floating selects did not give natural order");
    order_last_a: assert property (!FIVE_CH && core_reg.st == ssv_pkg::ST_OFF && core_next.st == ssv_pkg::ST_DELAY
        && tri_row == 5'd23 |=> core_reg.ord == 15'h4053)
        else $error("last select code did not give order four-three-two-one");
    disc_off_a: assert property ((discharge_en_out & ~channel_out_oe_out) == 5'h00
        && (core_reg.st != ssv_pkg::ST_RUN || discharge_en_out == 5'h00))
        else $error("discharge on for a released channel or while running");
    ch5_after4_a: assert property ($fell(channel_out_oe_out[4]) |-> $past(core_reg.chk[3]))
        else $error("channel five released before monitor four was good");
    hold_block_a: assert property (core_reg.st == ssv_pkg::ST_RUN && !hold_s
        |=> core_reg.st != ssv_pkg::ST_REV)
        else $error("reverse power-down started with enable-hold low");
endmodule : ssv_top
